// ==== timer_consts.vh ====
// constants for the triple timer/counter unit
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// register byte offsets on the peripheral bus
`define T0_BASE       8'h50
`define T1_BASE       8'h58
`define T2_BASE       8'h60
`define OFS_COUNT     8'h00
`define OFS_LIMIT_A   8'h02
`define OFS_LIMIT_B   8'h04
`define OFS_CTRL      8'h06

// mode/control word field positions
`define BIT_EN        15
`define BIT_WMASK     14
`define BIT_IRQ_EN    13
`define BIT_CSEL      12
`define BIT_MC        5
`define BIT_RTG       4
`define BIT_PRE       3
`define BIT_EXT       2
`define BIT_ALT       1
`define BIT_CONTINUOUS_RUN      0

// reset values
`define RST_COUNT     16'h0000
`define RST_LIMIT     16'h0000
`define RST_DUAL_T01  1'b1

// service slots: one timer per clock, four clock cycle
`define SLOT_LAST     2'h3
`define SLOT_T0       2'h0
`define SLOT_T1       2'h1
`define SLOT_T2       2'h2

`endif

// ==== pin_sync.v ====
// two-stage synchroniser with rising edge detect for a timer input pin
`timescale 1ns/1ps
module pin_sync
(
    input  wire clk_sys,
    input  wire rst,
    input  wire pin,
    output wire level,
    output wire rise
);
    reg meta;
    reg sync;
    reg prev;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // level is the second stage; rise also looks at the third stage (prev)
    assign level = sync;
    assign rise  = sync & ~prev;
endmodule // pin_sync

// ==== triple_timer_counter_unit.v ====
// three 16-bit timers with register bus and pin interface
`timescale 1ns/1ps
`include "timer_consts.vh"
module triple_timer_counter_unit
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [7:0]  addr,
    input  wire        wr,
    input  wire        rd,
    input  wire [15:0] wdata,
    output reg  [15:0] rdata,
    input  wire        timer_in0,
    input  wire        timer_in1,
    output wire        timer_out0,
    output wire        timer_out1,
    output wire [2:0]  irq_req,
    input  wire [2:0]  irq_clear
);
    reg  [1:0]  slot;
    wire [2:0]  pin_lvl;
    wire [2:0]  pin_rise;
    wire [2:0]  out_w;
    wire [2:0]  tc_w;
    wire [47:0] rd_w;
    wire        t2_tc;

    pin_sync u_sync0
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (timer_in0),
        .level   (pin_lvl[0]),
        .rise    (pin_rise[0])
    );

    pin_sync u_sync1
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (timer_in1),
        .level   (pin_lvl[1]),
        .rise    (pin_rise[1])
    );

    // timer 2 has no pins: gate held open so it runs on the quarter clock
    assign pin_lvl[2]  = 1'b1;
    assign pin_rise[2] = 1'b0;

    // round-robin service, slot 3 idle
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            slot <= 2'h0;
        end
        else if (slot == `SLOT_LAST)
        begin
            slot <= 2'h0;
        end
        else
        begin
            slot <= slot + 2'h1;
        end
    end

    assign t2_tc = tc_w[2];

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : tmr
            localparam       HAS_PINS = (i < 2);
            localparam [7:0] BASE     = (i == 0) ? `T0_BASE : (i == 1) ? `T1_BASE : `T2_BASE;
            localparam [1:0] SLOT     = (i == 0) ? `SLOT_T0 : (i == 1) ? `SLOT_T1 : `SLOT_T2;
            localparam       RST_ALT  = HAS_PINS ? `RST_DUAL_T01 : 1'b0;

            reg  [15:0] count;
            reg  [15:0] lim_a;
            reg  [15:0] lim_b;
            reg         en;
            reg         irq_en;
            reg         mc;
            reg         edge_restart_select;
            reg         pre;
            reg         external_clock_select;
            reg         dual_limit_select;
            reg         continuous_run;
            reg         csel;
            reg         armed;
            reg         edge_pend;
            reg         t2_pend;
            reg         out_q;
            reg         irq_q;
            reg         tc_q;

            wire        service;
            wire        ctrl_wr;
            wire        cnt_wr;
            wire        la_wr;
            wire        lb_wr;
            wire [15:0] lim;
            wire [15:0] nxt;
            wire        term;
            wire        src_tick;
            wire        gate_ok;
            wire        tick;
            wire        restart;
            wire        hit_tc;
            wire        halt;
            wire [15:0] ctrl_rd;

            assign service = (slot == SLOT);
            assign ctrl_wr = wr && (addr == BASE + `OFS_CTRL);
            assign cnt_wr  = wr && (addr == BASE + `OFS_COUNT);
            assign la_wr   = wr && (addr == BASE + `OFS_LIMIT_A);
            assign lb_wr   = HAS_PINS && wr && (addr == BASE + `OFS_LIMIT_B);

            assign lim  = csel ? lim_b : lim_a;
            assign nxt  = count + 16'h0001;
            // equality only, so a limit below count wraps through 0xffff first
            assign term = (nxt == lim);

            // event source: external edge, timer 2 pulse, or every service
            assign src_tick = external_clock_select ? edge_pend : (pre ? t2_pend : 1'b1);
            // gate level or restart arming only in internal clocking
            assign gate_ok  = external_clock_select || (edge_restart_select ? armed : pin_lvl[i]);
            assign tick     = en && service && src_tick && gate_ok;
            assign restart  = en && service && !external_clock_select && edge_restart_select && edge_pend;
            assign hit_tc   = tick && !restart && term;
            // single run: stop at A, or after B in dual mode
            assign halt     = !continuous_run && (!dual_limit_select || csel);

            assign ctrl_rd  = {en, 1'b0, irq_en, csel, 6'h00,
                               mc, edge_restart_select, pre, external_clock_select, dual_limit_select, continuous_run};

            assign rd_w[i*16 +: 16] = (addr == BASE + `OFS_CTRL)    ? ctrl_rd :
                                      (addr == BASE + `OFS_COUNT)   ? count   :
                                      (addr == BASE + `OFS_LIMIT_A) ? lim_a   :
                                      (HAS_PINS && addr == BASE + `OFS_LIMIT_B) ? lim_b :
                                      16'h0000;
            assign out_w[i]   = out_q;
            assign tc_w[i]    = tc_q;
            assign irq_req[i] = irq_q;

            // mode/control word
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    en     <= 1'b0;
                    irq_en <= 1'b0;
                    edge_restart_select    <= 1'b0;
                    pre    <= 1'b0;
                    external_clock_select    <= 1'b0;
                    dual_limit_select    <= RST_ALT;
                    continuous_run   <= 1'b0;
                end
                else
                begin
                    if (ctrl_wr)
                    begin
                        irq_en <= wdata[`BIT_IRQ_EN];
                        continuous_run   <= wdata[`BIT_CONTINUOUS_RUN];
                        if (HAS_PINS)
                        begin
                            edge_restart_select <= wdata[`BIT_RTG];
                            pre <= wdata[`BIT_PRE];
                            external_clock_select <= wdata[`BIT_EXT];
                            dual_limit_select <= wdata[`BIT_ALT];
                        end
                        else
                        begin
                            edge_restart_select <= 1'b0;
                            pre <= 1'b0;
                            external_clock_select <= 1'b0;
                            dual_limit_select <= 1'b0;
                        end
                    end
                    // a masked-in software write overrides a same-cycle halt
                    if (ctrl_wr && wdata[`BIT_WMASK])
                    begin
                        en <= wdata[`BIT_EN];
                    end
                    else if (hit_tc && halt)
                    begin
                        en <= 1'b0;
                    end
                end
            end

            // status: limit flag and compare select
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    mc   <= 1'b0;
                    csel <= 1'b0;
                end
                else
                begin
                    // set wins over a clearing write
                    if (hit_tc)
                    begin
                        mc <= 1'b1;
                    end
                    else if (ctrl_wr)
                    begin
                        mc <= wdata[`BIT_MC];
                    end
                    // clear in the writing clock too, so no cycle shows csel without dual
                    if (!dual_limit_select || (ctrl_wr && !wdata[`BIT_ALT]))
                    begin
                        csel <= 1'b0;
                    end
                    else if (hit_tc)
                    begin
                        csel <= ~csel;
                    end
                end
            end

            // count and limit registers
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    count <= `RST_COUNT;
                    lim_a <= `RST_LIMIT;
                    lim_b <= `RST_LIMIT;
                end
                else
                begin
                    if (la_wr)
                    begin
                        lim_a <= wdata;
                    end
                    if (lb_wr)
                    begin
                        lim_b <= wdata;
                    end
                    if (cnt_wr)
                    begin
                        count <= wdata;
                    end
                    else if (restart)
                    begin
                        count <= 16'h0000;
                    end
                    else if (tick)
                    begin
                        count <= term ? 16'h0000 : nxt;
                    end
                end
            end

            // pin and prescaler event capture between service slots
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    edge_pend <= 1'b0;
                    t2_pend   <= 1'b0;
                    armed     <= 1'b0;
                end
                else
                begin
                    // one pending edge per slot period, enough for edges 4 clocks apart
                    edge_pend <= en && ((edge_pend && !service) || pin_rise[i]);
                    t2_pend   <= en && ((t2_pend && !service) || t2_tc);
                    if (!en)
                    begin
                        armed <= 1'b0;
                    end
                    else if (restart)
                    begin
                        armed <= 1'b1;
                    end
                end
            end

            // output pin, terminal pulse and interrupt request
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    out_q <= 1'b1;
                    tc_q  <= 1'b0;
                    irq_q <= 1'b0;
                end
                else
                begin
                    out_q <= ~(dual_limit_select ? csel : hit_tc);
                    tc_q  <= hit_tc;
                    // latched so a later enable clear keeps it pending
                    irq_q <= (irq_q && !irq_clear[i]) || (hit_tc && irq_en);
                end
            end
        end
    endgenerate

    assign timer_out0 = out_w[0];
    assign timer_out1 = out_w[1];

    // read data registered; unmapped addresses read zero
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
        end
        else if (rd)
        begin
            rdata <= rd_w[15:0] | rd_w[31:16] | rd_w[47:32];
        end
    end
endmodule // triple_timer_counter_unit

// ==== pin_model.sv ====
// stimulus model for the timer input pins
`timescale 1ns/1ps
module pin_model
(
    input  wire       clk_sys,
    input  wire [1:0] level,
    input  wire [7:0] edges,
    input  wire       go,
    output wire       timer_in0,
    output wire       timer_in1
);
    reg [7:0] left = 8'h00;
    reg [1:0] ph   = 2'h0;
    // bursts use the tightest edge spacing the timer must still take
    always @(posedge clk_sys)
    begin
        ph <= go ? 2'h0 : ph + 2'h1;
        if (go)
            left <= edges;
        else if (left != 8'h00 && ph == 2'h3)
            left <= left - 8'h01;
    end
    assign timer_in0 = (left != 8'h00) ? ph[1] : level[0];
    assign timer_in1 = level[1];
endmodule // pin_model

// ==== timer_unit_properties.sv ====
// port assertions for the timer unit
`timescale 1ns/1ps
module timer_unit_checker
(
    input wire        clk_sys,
    input wire        rst,
    input wire [7:0]  addr,
    input wire        wr,
    input wire        rd,
    input wire [15:0] wdata,
    input wire [15:0] rdata,
    input wire        timer_in0,
    input wire        timer_in1,
    input wire        timer_out0,
    input wire        timer_out1,
    input wire [2:0]  irq_req,
    input wire [2:0]  irq_clear
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    release_outputs_high_a: assert property ($fell(rst) |-> timer_out0 && timer_out1)
        else $error("timer output low after reset");
    irq_stays_latched_a: assert property (!(|($past(irq_req) & ~$past(irq_clear) & ~irq_req)))
        else $error("interrupt request dropped without clear");
    read_data_holds_a: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without read");
    out0_pulse_spacing_a: assert property ($rose(timer_out0) |-> timer_out0[*3])
        else $error("timer 0 output toggles too fast");
    out1_pulse_spacing_a: assert property ($rose(timer_out1) |-> timer_out1[*3])
        else $error("timer 1 output toggles too fast");
    ctrl_zero_bits_a: assert property (rd && (addr == 8'h56 || addr == 8'h5e || addr == 8'h66)
        |=> rdata[14] == 1'b0 && rdata[11:6] == 6'h00)
        else $error("control word reads reserved bits set");
    timer2_tied_bits_a: assert property (rd && addr == 8'h66
        |=> rdata[12] == 1'b0 && rdata[4:1] == 4'h0)
        else $error("timer 2 fixed mode bits not zero");
    unmapped_reads_zero_a: assert property (rd && (addr == 8'h64 || addr < 8'h50 || addr > 8'h67)
        |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
endmodule // timer_unit_checker

bind triple_timer_counter_unit timer_unit_checker i_chk
(
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata), .timer_in0(timer_in0), .timer_in1(timer_in1),
    .timer_out0(timer_out0), .timer_out1(timer_out1), .irq_req(irq_req),
    .irq_clear(irq_clear)
);

// ==== tb.sv ====
// self-checking testbench for the timer unit
`timescale 1ns/1ps
module tb;
    reg         clk_sys;
    reg         rst;
    reg  [7:0]  addr;
    reg         wr;
    reg         rd;
    reg  [15:0] wdata;
    wire [15:0] rdata;
    wire        timer_in0;
    wire        timer_in1;
    wire        timer_out0;
    wire        timer_out1;
    wire [2:0]  irq_req;
    reg  [2:0]  irq_clear;
    reg  [1:0]  level;
    reg  [7:0]  edges;
    reg         go;
    reg  [15:0] v;
    integer     failures;
    integer     total_checks;
    integer     low0;
    integer     low1;

    triple_timer_counter_unit i_dut
    (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .timer_in0(timer_in0), .timer_in1(timer_in1),
        .timer_out0(timer_out0), .timer_out1(timer_out1), .irq_req(irq_req),
        .irq_clear(irq_clear)
    );
    pin_model i_pins
    (
        .clk_sys(clk_sys), .level(level), .edges(edges), .go(go),
        .timer_in0(timer_in0), .timer_in1(timer_in1)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        low0 = low0 + (timer_out0 === 1'b0);
        low1 = low1 + (timer_out1 === 1'b0);
    end

    task idle(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask

    task wreg(input [7:0] a, input [15:0] d);
    begin
        @(negedge clk_sys);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys);
        wr = 1'b0;
    end
    endtask

    task rreg(input [7:0] a, output [15:0] d);
    begin
        @(negedge clk_sys);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
        d = rdata;
    end
    endtask

    task check(input [15:0] seen, input [15:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    end
    endtask

    task rchk(input [7:0] a, input [15:0] e);
    begin
        rreg(a, v);
        check(v, e);
    end
    endtask

    task wait_irq(input integer n);
        integer k;
    begin
        for (k = 0; k < 100 && irq_req[n] !== 1'b1; k = k + 1)
            @(negedge clk_sys);
        check({15'h0000, irq_req[n]}, 16'h0001);
    end
    endtask

    task finish_test;
    begin
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    // generous margin over the roughly 430 cycles the tests need
    initial
    begin
        #500000;
        failures = failures + 1;
        finish_test;
    end

    initial
    begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
        irq_clear = 3'b000;
        level = 2'b11;
        edges = 8'h00;
        go = 1'b0;
        failures = 0;
        total_checks = 0;
        rst = 1'b1;
        idle(8);
        rst = 1'b0;
        rchk(8'h56, 16'h0002);
        rchk(8'h66, 16'h0000);
        check({15'h0000, timer_out0 & timer_out1}, 16'h0001);
        wreg(8'h56, 16'h9fc1);
        rchk(8'h56, 16'h0001);
        wreg(8'h54, 16'h1234);
        rchk(8'h54, 16'h1234);
        wreg(8'h64, 16'h1234);
        rchk(8'h64, 16'h0000);
        $display("test registers done");
        wreg(8'h52, 16'h0005);
        wreg(8'h50, 16'h0000);
        low0 = 0;
        wreg(8'h56, 16'he000);
        wait_irq(0);
        idle(4);
        check(low0[15:0], 16'h0001);
        rchk(8'h50, 16'h0000);
        rchk(8'h56, 16'h2020);
        wreg(8'h56, 16'h0000);
        check({15'h0000, irq_req[0]}, 16'h0001);
        rchk(8'h56, 16'h0000);
        $display("test single run done");
        level = 2'b10;
        wreg(8'h52, 16'h0000);
        wreg(8'h56, 16'hc001);
        idle(40);
        rchk(8'h50, 16'h0000);
        level = 2'b11;
        idle(3);
        wreg(8'h50, 16'h0000);
        idle(40);
        rreg(8'h50, v);
        check({15'h0000, v >= 16'h0009 && v <= 16'h000b}, 16'h0001);
        $display("test gate done");
        level = 2'b10;
        wreg(8'h56, 16'h4000);
        wreg(8'h50, 16'h0100);
        wreg(8'h56, 16'hc011);
        idle(20);
        rchk(8'h50, 16'h0100);
        level = 2'b11;
        idle(12);
        rreg(8'h50, v);
        check({15'h0000, v < 16'h0008}, 16'h0001);
        wreg(8'h56, 16'h4011);
        rreg(8'h50, v);
        level = 2'b10;
        idle(4);
        level = 2'b11;
        idle(12);
        rchk(8'h50, v);
        $display("test restart done");
        level = 2'b10;
        wreg(8'h50, 16'h0000);
        wreg(8'h56, 16'hc005);
        edges = 8'h0a;
        go = 1'b1;
        idle(1);
        go = 1'b0;
        idle(60);
        rchk(8'h50, 16'h000a);
        $display("test external clock done");
        wreg(8'h5a, 16'h0002);
        wreg(8'h5c, 16'h0003);
        low1 = 0;
        wreg(8'h5e, 16'he002);
        wait_irq(1);
        irq_clear = 3'b010;
        idle(1);
        irq_clear = 3'b000;
        check({15'h0000, irq_req[1]}, 16'h0000);
        wait_irq(1);
        idle(8);
        check(low1[15:0], 16'h000c);
        rchk(8'h5e, 16'h2022);
        $display("test dual limit done");
        wreg(8'h56, 16'hc009);
        level = 2'b11;
        wreg(8'h62, 16'h0002);
        wreg(8'h60, 16'h0000);
        wreg(8'h50, 16'h0000);
        wreg(8'h66, 16'he001);
        wait_irq(2);
        idle(80);
        rreg(8'h50, v);
        check({15'h0000, v >= 16'h0009 && v <= 16'h000b}, 16'h0001);
        $display("test prescale done");
        finish_test;
    end
endmodule // tb
